// >>> hw/msc_accel_decode.sv
/*
 Maps a 5-bit acceleration code to a rate in mHz/s (or mHz/s2).
 Assumes the caller registers the result.
*/
`timescale 1ns/100ps
`include "msc_params.svh"
module msc_accel_decode
  import msc_pkg::*;
(
  msc_accel_if.dec bus
);
  always_comb begin
    case (bus.code)
      5'h00: bus.rate = 25'h0000005;
      5'h01: bus.rate = 25'h000000A;
      5'h02: bus.rate = 25'h0000019;
      5'h03: bus.rate = 25'h0000032;
      5'h04: bus.rate = 25'h0000064;
      5'h05: bus.rate = 25'h00000FA;
      5'h06: bus.rate = 25'h00001F4;
      5'h07: bus.rate = 25'h00003E8;
      5'h08: bus.rate = 25'h00009C4;
      5'h09: bus.rate = 25'h0001388;
      5'h0A: bus.rate = 25'h0001D4C;
      5'h0B: bus.rate = 25'h0002710;
      5'h0C: bus.rate = 25'h00030D4;
      5'h0D: bus.rate = 25'h0003A98;
      5'h0E: bus.rate = 25'h0004E20;
      5'h0F: bus.rate = 25'h0007530;
      5'h10: bus.rate = 25'h0009C40;
      5'h11: bus.rate = 25'h000C350;
      5'h12: bus.rate = 25'h000EA60;
      5'h13: bus.rate = 25'h00124F8;
      5'h14: bus.rate = 25'h00186A0;
      5'h15: bus.rate = 25'h001E848;
      5'h16: bus.rate = 25'h00249F0;
      5'h17: bus.rate = 25'h002AB98;
      5'h18: bus.rate = 25'h0030D40;
      5'h19: bus.rate = 25'h003D090;
      5'h1A: bus.rate = 25'h00493E0;
      5'h1B: bus.rate = 25'h0061A80;
      5'h1C: bus.rate = 25'h007A120;
      5'h1D: bus.rate = 25'h00B71B0;
      5'h1E: bus.rate = 25'h00F4240;
      default: bus.rate = `MSC_ACC_UNLIMITED;
    endcase
  end
endmodule : msc_accel_decode

// >>> hw/msc_accel_if.sv
/*
 Carrier between the settings register and one acceleration decoder.
 Assumes a combinational decoder on the dec side.
*/
`timescale 1ns/100ps
interface msc_accel_if;
  import msc_pkg::*;
  logic [4:0] code;
  msc_rate_t rate;
  modport src (output code, input rate);
  modport dec (input code, output rate);
endinterface : msc_accel_if

// >>> hw/msc_params.svh
/*
 Offsets, field positions, reset values and lookup constants of the
 open-loop startup settings word. Assumes inclusion by bare name only.
*/
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

`define MSC_ADDR 8'h84
`define MSC_RESET_WORD 32'h00000000
`define MSC_PARITY_BIT 31
`define MSC_SRC_BIT 30
`define MSC_DUTY_MSB 29
`define MSC_DUTY_LSB 27
`define MSC_THR_MSB 26
`define MSC_THR_LSB 23
`define MSC_ACC1_MSB 22
`define MSC_ACC1_LSB 18
`define MSC_ACC2_MSB 17
`define MSC_ACC2_LSB 13
`define MSC_MIN_MSB 5
`define MSC_MIN_LSB 2
`define MSC_STORE_LSB 2
`define MSC_RSVD_READ 2'h0
`define MSC_THR_STEP_MV 11'h064
`define MSC_ACC_UNLIMITED 25'h1F3FC18
`define MSC_DUTY_FULL 10'h3E8
`define MSC_MIN_FIRST 10'h00F

`endif

// >>> hw/msc_pkg.sv
/*
 Types shared by the startup settings block and its rate decoder.
 Assumes nothing of its surroundings.
*/
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_SRC_DEDICATED = 2'h1,
    MSC_SRC_GENERAL = 2'h2
  } msc_src_t;
  typedef logic [24:0] msc_rate_t;
  typedef logic [9:0] msc_permille_t;
endpackage : msc_pkg

// >>> hw/msc_startup_config.sv
/*
 Open-loop startup settings word with its register port and decoded
 field outputs for the startup and current-sense logic.
 Assumes all port inputs are synchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "msc_params.svh"
module msc_startup_config
  import msc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] wrData,
  output logic [31:0] rdData,
  output logic rdValid,
  input wire logic [3:0] generalCurrentCap,
  output msc_src_t limitSource,
  output logic [3:0] effectiveCurrentCap,
  output logic [10:0] openLoopCurrentThreshold,
  output logic thresholdInvalid,
  output msc_permille_t openLoopDutyCap,
  output msc_rate_t startupAccelFirstCoeff,
  output msc_rate_t startupAccelSecondCoeff,
  output msc_permille_t minDutyCycle,
  output logic parityBit
);
  logic [31:`MSC_STORE_LSB] word_ff;
  logic [31:0] rdData_ff;
  logic rdValid_ff;
  msc_src_t limitSource_ff;
  logic [3:0] effCap_ff;
  logic [10:0] thrMv_ff;
  logic thrInvalid_ff;
  msc_permille_t dutyCap_ff;
  msc_rate_t acc1_ff;
  msc_rate_t acc2_ff;
  msc_permille_t minDuty_ff;
  logic parity_ff;
  logic addrHit;
  logic [3:0] thrCode;
  logic [2:0] dutyCode;
  logic [3:0] minCode;
  msc_permille_t nxt_dutyCap;
  msc_permille_t nxt_minDuty;
  logic [10:0] nxt_thrMv;

  msc_accel_if accFirst();
  msc_accel_if accSecond();

  assign addrHit = (regAddr == `MSC_ADDR);
  assign thrCode = word_ff[`MSC_THR_MSB:`MSC_THR_LSB];
  assign dutyCode = word_ff[`MSC_DUTY_MSB:`MSC_DUTY_LSB];
  assign minCode = word_ff[`MSC_MIN_MSB:`MSC_MIN_LSB];
  assign accFirst.code = word_ff[`MSC_ACC1_MSB:`MSC_ACC1_LSB];
  assign accSecond.code = word_ff[`MSC_ACC2_MSB:`MSC_ACC2_LSB];

  msc_accel_decode u_accFirst (
    .bus(accFirst)
  );
  msc_accel_decode u_accSecond (
    .bus(accSecond)
  );

  // Writes reach only bits 31:2; the reserved pair is never stored.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_ff <= 30'(`MSC_RESET_WORD >> `MSC_STORE_LSB);
    end else if (ce && wrEn && addrHit) begin
      word_ff <= wrData[31:`MSC_STORE_LSB];
    end
  end

  // Reads of any other address answer zero, still with a valid strobe.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_ff <= 32'h00000000;
      rdValid_ff <= 1'b0;
    end else if (ce) begin
      rdValid_ff <= rdEn;
      if (rdEn && addrHit) begin
        rdData_ff <= {word_ff, `MSC_RSVD_READ};
      end else begin
        rdData_ff <= 32'h00000000;
      end
    end
  end

  always_comb begin
    case (dutyCode)
      3'h0: nxt_dutyCap = 10'h064;
      3'h1: nxt_dutyCap = 10'h096;
      3'h2: nxt_dutyCap = 10'h0C8;
      3'h3: nxt_dutyCap = 10'h0FA;
      3'h4: nxt_dutyCap = 10'h12C;
      3'h5: nxt_dutyCap = 10'h190;
      3'h6: nxt_dutyCap = 10'h1F4;
      default: nxt_dutyCap = `MSC_DUTY_FULL;
    endcase
  end

  always_comb begin
    case (minCode)
      4'h0: nxt_minDuty = `MSC_MIN_FIRST;
      4'h1: nxt_minDuty = 10'h014;
      4'h2: nxt_minDuty = 10'h01E;
      4'h3: nxt_minDuty = 10'h028;
      4'h4: nxt_minDuty = 10'h032;
      4'h5: nxt_minDuty = 10'h03C;
      4'h6: nxt_minDuty = 10'h046;
      4'h7: nxt_minDuty = 10'h050;
      4'h8: nxt_minDuty = 10'h05A;
      4'h9: nxt_minDuty = 10'h064;
      4'hA: nxt_minDuty = 10'h078;
      4'hB: nxt_minDuty = 10'h096;
      4'hC: nxt_minDuty = 10'h0AF;
      4'hD: nxt_minDuty = 10'h0C8;
      4'hE: nxt_minDuty = 10'h0FA;
      default: nxt_minDuty = 10'h12C;
    endcase
  end

  assign nxt_thrMv = 11'({7'h00, thrCode} * `MSC_THR_STEP_MV);

  // Decoded fields follow the stored word one cycle later.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      limitSource_ff <= MSC_SRC_DEDICATED;
      effCap_ff <= 4'h0;
    end else if (ce) begin
      if (word_ff[`MSC_SRC_BIT]) begin
        limitSource_ff <= MSC_SRC_GENERAL;
        effCap_ff <= generalCurrentCap;
      end else begin
        limitSource_ff <= MSC_SRC_DEDICATED;
        effCap_ff <= thrCode;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      thrMv_ff <= 11'h000;
      thrInvalid_ff <= 1'b1;
    end else if (ce) begin
      thrMv_ff <= nxt_thrMv;
      thrInvalid_ff <= (thrCode == 4'h0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dutyCap_ff <= 10'h064;
      minDuty_ff <= `MSC_MIN_FIRST;
    end else if (ce) begin
      dutyCap_ff <= nxt_dutyCap;
      minDuty_ff <= nxt_minDuty;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc1_ff <= 25'h0000005;
      acc2_ff <= 25'h0000005;
      parity_ff <= 1'b0;
    end else if (ce) begin
      acc1_ff <= accFirst.rate;
      acc2_ff <= accSecond.rate;
      parity_ff <= word_ff[`MSC_PARITY_BIT];
    end
  end

  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;
  assign limitSource = limitSource_ff;
  assign effectiveCurrentCap = effCap_ff;
  assign openLoopCurrentThreshold = thrMv_ff;
  assign thresholdInvalid = thrInvalid_ff;
  assign openLoopDutyCap = dutyCap_ff;
  assign startupAccelFirstCoeff = acc1_ff;
  assign startupAccelSecondCoeff = acc2_ff;
  assign minDutyCycle = minDuty_ff;
  assign parityBit = parity_ff;

  property p_write_read;
    @(posedge ref_clk) disable iff (rst)
    ce && wrEn && addrHit && !rdEn ##1 ce && rdEn && addrHit && !wrEn
      |=> rdValid && rdData[31:2] == $past(wrData[31:2], 2);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("Read back differs from written word.");

  property p_src_select;
    @(posedge ref_clk) disable iff (rst)
    ce && word_ff[`MSC_SRC_BIT]
      |=> limitSource == MSC_SRC_GENERAL && effectiveCurrentCap == $past(generalCurrentCap);
  endproperty
  a_src_select: assert property (p_src_select)
    else $error("General limit not applied.");

  property p_src_dedicated;
    @(posedge ref_clk) disable iff (rst)
    ce && !word_ff[`MSC_SRC_BIT]
      |=> limitSource == MSC_SRC_DEDICATED && effectiveCurrentCap == $past(thrCode);
  endproperty
  a_src_dedicated: assert property (p_src_dedicated)
    else $error("Dedicated limit not applied.");

  property p_duty_cap;
    @(posedge ref_clk) disable iff (rst)
    ce && dutyCode == 3'h7 |=> openLoopDutyCap == `MSC_DUTY_FULL;
  endproperty
  a_duty_cap: assert property (p_duty_cap)
    else $error("Duty cap code 7 is not full duty.");

  property p_threshold;
    @(posedge ref_clk) disable iff (rst)
    ce |=> openLoopCurrentThreshold == {7'h00, $past(thrCode)} * 11'h064
      && thresholdInvalid == ($past(thrCode) == 4'h0);
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("Threshold voltage mismatch.");

  property p_accel_first;
    @(posedge ref_clk) disable iff (rst)
    ce && accFirst.code == 5'h1E |=> startupAccelFirstCoeff == 25'h00F4240;
  endproperty
  a_accel_first: assert property (p_accel_first)
    else $error("First acceleration top entry wrong.");

  property p_accel_unlim;
    @(posedge ref_clk) disable iff (rst)
    ce && accFirst.code == 5'h1F |=> startupAccelFirstCoeff == `MSC_ACC_UNLIMITED;
  endproperty
  a_accel_unlim: assert property (p_accel_unlim)
    else $error("Unlimited rate not saturated.");

  property p_accel_second;
    @(posedge ref_clk) disable iff (rst)
    ce && accSecond.code == 5'h00 |=> startupAccelSecondCoeff == 25'h0000005;
  endproperty
  a_accel_second: assert property (p_accel_second)
    else $error("Second acceleration first entry wrong.");

  property p_min_duty;
    @(posedge ref_clk) disable iff (rst)
    ce && minCode == 4'hF |=> minDutyCycle == 10'h12C;
  endproperty
  a_min_duty: assert property (p_min_duty)
    else $error("Minimum duty top entry wrong.");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
    rdValid |-> rdData[1:0] == `MSC_RSVD_READ && parityBit == $past(word_ff[31]) || !$past(ce);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits or parity wrong.");
endmodule : msc_startup_config

// >>> verification/msc_startup_config_tb.sv
/*
 Self-checking bench for the open-loop startup settings word: register
 port, decoded field outputs, clock enable and reset values.
 Assumes the design package, parameter header and design files compile first.
*/
`timescale 1ns/100ps
`include "msc_params.svh"
module msc_startup_config_tb
  import msc_pkg::*;
;
  logic refClk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] wrData = 32'h00000000;
  logic [3:0] gcc = 4'h0;
  logic [31:0] rdData;
  logic rdValid;
  msc_src_t limitSource;
  logic [3:0] effCap;
  logic [10:0] thr;
  logic thrInvalid;
  msc_permille_t dutyCap;
  msc_rate_t acc1;
  msc_rate_t acc2;
  msc_permille_t minDuty;
  logic parityBit;
  int nErrors = 0;
  int numChecks = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [4:0] c;
  // Rates in mHz/s for codes 0 to 1Fh; the last entry is the saturated unlimited rate.
  int accTab[32] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000, 7500, 10000,
    12500, 15000, 20000, 30000, 40000, 50000, 60000, 75000, 100000, 125000, 150000,
    175000, 200000, 250000, 300000, 400000, 500000, 750000, 1000000, 32767000};
  int dutyTab[8] = '{100, 150, 200, 250, 300, 400, 500, 1000};
  int minTab[16] = '{15, 20, 30, 40, 50, 60, 70, 80, 90, 100, 120, 150, 175, 200, 250, 300};

  msc_startup_config i_msc_startup_config (
    .ref_clk(refClk), .rst(rst), .ce(ce), .wrEn(wrEn), .rdEn(rdEn),
    .regAddr(regAddr), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .generalCurrentCap(gcc), .limitSource(limitSource), .effectiveCurrentCap(effCap),
    .openLoopCurrentThreshold(thr), .thresholdInvalid(thrInvalid),
    .openLoopDutyCap(dutyCap), .startupAccelFirstCoeff(acc1),
    .startupAccelSecondCoeff(acc2), .minDutyCycle(minDuty), .parityBit(parityBit)
  );

  initial begin
    forever #25 refClk = ~refClk;
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // One request: raised after an edge, taken at the next edge, dropped after it.
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    @(posedge refClk);
    #1;
    wrEn = w;
    rdEn = r;
    regAddr = a;
    wrData = v;
    @(posedge refClk);
    #1;
    wrEn = 1'b0;
    rdEn = 1'b0;
  endtask : xfer

  // A write taken at one edge and a read of the same word taken at the very next edge.
  task automatic wrRd(input logic [31:0] v);
    @(posedge refClk);
    #1;
    wrEn = 1'b1;
    regAddr = `MSC_ADDR;
    wrData = v;
    @(posedge refClk);
    #1;
    wrEn = 1'b0;
    rdEn = 1'b1;
    @(posedge refClk);
    #1;
    rdEn = 1'b0;
  endtask : wrRd

  // Called just after the edge that took the read, while the answer stands.
  task automatic rdChk(input logic [31:0] exp);
    chk("rdValid", {31'h0, rdValid}, 32'h1);
    chk("rdData", rdData, exp);
    @(posedge refClk);
    #1;
    chk("rdValid drop", {31'h0, rdValid}, 32'h0);
  endtask : rdChk

  task automatic results();
    $display("Checks %0d, mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      $display("[ERR] %0t run did not finish in time", $time);
      results();
    end
  end

  initial begin
    repeat (4) @(posedge refClk);
    #1;
    rst = 1'b0;
    chk("reset src", 32'(limitSource), 32'(MSC_SRC_DEDICATED));
    chk("reset invalid", {31'h0, thrInvalid}, 32'h1);
    chk("reset duty", 32'(dutyCap), 32'h00000064);
    chk("reset acc1", 32'(acc1), 32'h00000005);
    chk("reset min", 32'(minDuty), 32'h0000000F);
    xfer(1'b0, 1'b1, `MSC_ADDR, 32'h0);
    rdChk(32'h0);
    $display("Test reset done");
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      d = {c[1], c[0], c[2:0], c[3:0], c, 5'(31 - i), 7'h55, c[3:0], 2'h3};
      gcc = ~c[3:0];
      xfer(1'b1, 1'b0, `MSC_ADDR, d);
      repeat (2) @(posedge refClk);
      #1;
      chk("src", 32'(limitSource), 32'(c[0] ? MSC_SRC_GENERAL : MSC_SRC_DEDICATED));
      chk("cap", 32'(effCap), 32'(c[0] ? gcc : c[3:0]));
      chk("duty", 32'(dutyCap), 32'(dutyTab[c[2:0]]));
      chk("thr", 32'(thr), 32'(c[3:0]) * 32'h00000064);
      chk("invalid", {31'h0, thrInvalid}, {31'h0, c[3:0] == 4'h0});
      chk("acc1", 32'(acc1), 32'(accTab[c]));
      chk("acc2", 32'(acc2), 32'(accTab[31 - i]));
      chk("min", 32'(minDuty), 32'(minTab[c[3:0]]));
      chk("parity", {31'h0, parityBit}, {31'h0, c[1]});
      xfer(1'b0, 1'b1, `MSC_ADDR, 32'h0);
      rdChk({d[31:2], 2'h0});
    end
    $display("Test field decode done");
    gcc = 4'h3;
    @(posedge refClk);
    #1;
    chk("cap follow", 32'(effCap), 32'h3);
    xfer(1'b1, 1'b1, `MSC_ADDR, 32'h12345678);
    rdChk({d[31:2], 2'h0});
    xfer(1'b1, 1'b0, 8'h80, 32'hFFFFFFFF);
    xfer(1'b0, 1'b1, 8'h80, 32'h0);
    rdChk(32'h0);
    xfer(1'b0, 1'b1, `MSC_ADDR, 32'h0);
    rdChk(32'h12345678);
    ce = 1'b0;
    xfer(1'b1, 1'b0, `MSC_ADDR, 32'hA5A5A5A4);
    ce = 1'b1;
    xfer(1'b0, 1'b1, `MSC_ADDR, 32'h0);
    rdChk(32'h12345678);
    $display("Test access corners done");
    wrRd(32'h9ABCDEF0);
    rdChk(32'h9ABCDEF0);
    @(posedge refClk);
    #1;
    rst = 1'b1;
    @(posedge refClk);
    #1;
    rst = 1'b0;
    xfer(1'b0, 1'b1, `MSC_ADDR, 32'h0);
    rdChk(32'h00000000);
    chk("rerun src", 32'(limitSource), 32'(MSC_SRC_DEDICATED));
    chk("rerun acc2", 32'(acc2), 32'h00000005);
    chk("rerun parity", {31'h0, parityBit}, 32'h0);
    $display("Test back to back and mid-run reset done");
    results();
  end
endmodule : msc_startup_config_tb
